/* rtl/tlic_core.sv */
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
// Function
// - priority mode: high 000008h, low 000018h
// - high request preempts running low routine
// - each source has flag, enable, level bits
// - priority mode only when reset_control bit 7
// - bit7 gates high sources, bit6 low sources
// - flag, enable, global enable all set vectors
// - reset clears priority mode; levels ignored then
// - compat: bit6 peripheral group, bit7 global
// - compat mode: every interrupt to 000008h
// - acceptance clears the global enable in use
// - low held off during high routine
// - push return address, load vector into pc
// - return instruction re-sets enable in use
// - external event latency three to four cycles
// - flags set regardless of any enable
// - usb events merge into one flag, bit 5
`include "tlic_params.svh"
module tlic_core #(
	parameter int NSRC = 8,
	parameter int NPERIPH_BASE = 3
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic [NSRC-1:0] i_event,
	input wire logic [NSRC-1:0] i_ext_pin,
	input wire logic [7:0] i_usb_events,
	input wire logic i_cycle_end,
	input wire logic i_return_from_interrupt_instr,
	input wire tlic_pkg::tlic_addr_t i_return_addr,
	output logic o_vector_load,
	output tlic_pkg::tlic_addr_t o_vector_addr,
	output logic o_stack_push,
	output tlic_pkg::tlic_addr_t o_push_addr,
	output logic o_in_high,
	output logic o_in_low
);
	import tlic_pkg::*;

	// ==========================================
	// control and per-source state
	logic priority_mode_enable;
	logic high_level_global_enable;
	logic low_level_global_enable;
	logic [NSRC-1:0] src_flag;
	logic [NSRC-1:0] src_enable;
	logic [NSRC-1:0] src_level;
	logic [NSRC-1:0] ext_s1;
	logic [NSRC-1:0] ext_s2;
	logic [NSRC-1:0] ext_prev;
	logic [7:0] usb_s1;
	logic [7:0] usb_s2;
	tlic_state_t state;
	tlic_state_t stacked;
	logic take_high;
	logic take_low;
	logic [NSRC-1:0] hit;
	logic [NSRC-1:0] set_ev;

	// ==========================================
	// eligibility decode
	function automatic logic is_periph(input int idx);
		return idx >= NPERIPH_BASE;
	endfunction

	// ext pins pass two flops; rising edge after sync gives 3-4 cycle latency
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ext_s1 <= '0;
			ext_s2 <= '0;
			ext_prev <= '0;
			usb_s1 <= '0;
			usb_s2 <= '0;
		end else begin
			ext_s1 <= i_ext_pin;
			ext_s2 <= ext_s1;
			ext_prev <= ext_s2;
			usb_s1 <= i_usb_events;
			usb_s2 <= usb_s1;
		end
	end

	always_comb begin
		set_ev = i_event | (ext_s2 & ~ext_prev);
		set_ev[`TLIC_BIT_USB] = set_ev[`TLIC_BIT_USB] | (|usb_s2);
	end

	genvar g;
	generate
		for (g = 0; g < NSRC; g++) begin : g_src
			always_comb begin
				if (!src_flag[g] || !src_enable[g]) begin
					hit[g] = 1'b0;
				end else if (priority_mode_enable) begin
					hit[g] = src_level[g] ? high_level_global_enable : low_level_global_enable;
				end else begin
					hit[g] = high_level_global_enable && (!is_periph(g) || low_level_global_enable);
				end
			end
		end
	endgenerate

	always_comb begin
		take_high = 1'b0;
		take_low = 1'b0;
		if (i_cycle_end && !o_vector_load) begin
			if (priority_mode_enable) begin
				take_high = |(hit & src_level) && state != TLIC_HIGH;
				take_low = !take_high && |(hit & ~src_level) && state == TLIC_IDLE;
			end else begin
				take_high = |hit && state == TLIC_IDLE;
			end
		end
	end

	// ==========================================
	// flags: event set wins over software clear
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			src_flag <= '0;
		end else if (i_wr && i_addr == `TLIC_OFS_FLAG) begin
			src_flag <= i_wdata[NSRC-1:0] | set_ev;
		end else begin
			src_flag <= src_flag | set_ev;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			src_enable <= '0;
			src_level <= '1;
		end else if (i_wr && i_addr == `TLIC_OFS_ENABLE) begin
			src_enable <= i_wdata[NSRC-1:0];
		end else if (i_wr && i_addr == `TLIC_OFS_LEVEL) begin
			src_level <= i_wdata[NSRC-1:0];
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			priority_mode_enable <= 1'b0;
		end else if (i_wr && i_addr == `TLIC_OFS_RESET_CONTROL_REG) begin
			priority_mode_enable <= i_wdata[`TLIC_BIT_PRIO_EN];
		end
	end

	// ==========================================
	// global enables: hardware clear on entry, set on return
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			high_level_global_enable <= 1'b0;
			low_level_global_enable <= 1'b0;
		end else if (take_high) begin
			high_level_global_enable <= 1'b0;
		end else if (take_low) begin
			low_level_global_enable <= 1'b0;
		end else if (i_return_from_interrupt_instr) begin
			// in priority mode re-enable the level being left
			if (!priority_mode_enable || state == TLIC_HIGH || state == TLIC_IDLE) begin
				high_level_global_enable <= 1'b1;
			end else begin
				low_level_global_enable <= 1'b1;
			end
		end else if (i_wr && i_addr == `TLIC_OFS_INTERRUPT_CONTROL_REG) begin
			high_level_global_enable <= i_wdata[`TLIC_BIT_GIE_HI];
			low_level_global_enable <= i_wdata[`TLIC_BIT_GIE_LO];
		end
	end

	// ==========================================
	// service state; one nesting level, high over low
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= TLIC_IDLE;
			stacked <= TLIC_IDLE;
		end else if (take_high) begin
			stacked <= state;
			state <= TLIC_HIGH;
		end else if (take_low) begin
			state <= TLIC_LOW;
		end else if (i_return_from_interrupt_instr) begin
			case (state)
				TLIC_HIGH: begin
					state <= stacked;
					stacked <= TLIC_IDLE;
				end
				TLIC_LOW: state <= TLIC_IDLE;
				default: state <= TLIC_IDLE;
			endcase
		end
	end

	// ==========================================
	// core handoff, one-cycle pulses
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_vector_load <= 1'b0;
			o_stack_push <= 1'b0;
			o_vector_addr <= '0;
			o_push_addr <= '0;
		end else begin
			o_vector_load <= take_high | take_low;
			o_stack_push <= take_high | take_low;
			if (take_high) begin
				o_vector_addr <= `TLIC_VEC_HIGH;
				o_push_addr <= i_return_addr;
			end else if (take_low) begin
				o_vector_addr <= `TLIC_VEC_LOW;
				o_push_addr <= i_return_addr;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_in_high <= 1'b0;
			o_in_low <= 1'b0;
		end else begin
			o_in_high <= take_high || (state == TLIC_HIGH && !i_return_from_interrupt_instr);
			o_in_low <= take_low || (!take_high && state == TLIC_LOW && !i_return_from_interrupt_instr);
		end
	end

	// ==========================================
	// register reads, data one cycle after strobe
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= `TLIC_RST_BYTE;
		end else if (i_rd) begin
			case (i_addr)
				`TLIC_OFS_RESET_CONTROL_REG: o_rdata <= {priority_mode_enable, 7'h00};
				`TLIC_OFS_INTERRUPT_CONTROL_REG: o_rdata <= {high_level_global_enable, low_level_global_enable, 6'h00};
				`TLIC_OFS_FLAG: o_rdata <= 8'(src_flag);
				`TLIC_OFS_ENABLE: o_rdata <= 8'(src_enable);
				`TLIC_OFS_LEVEL: o_rdata <= 8'(src_level);
				`TLIC_OFS_STATUS: o_rdata <= {5'h00, state};
				default: o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end
endmodule

/* rtl/tlic_params.svh */
`ifndef TLIC_PARAMS_SVH
`define TLIC_PARAMS_SVH
// ==========================================
// register offsets (word index on the plain port)
`define TLIC_OFS_RESET_CONTROL_REG 4'h0
`define TLIC_OFS_INTERRUPT_CONTROL_REG 4'h1
`define TLIC_OFS_FLAG 4'h2
`define TLIC_OFS_ENABLE 4'h3
`define TLIC_OFS_LEVEL 4'h4
`define TLIC_OFS_STATUS 4'h5
// ==========================================
// field positions
`define TLIC_BIT_PRIO_EN 7
`define TLIC_BIT_GIE_HI 7
`define TLIC_BIT_GIE_LO 6
`define TLIC_BIT_USB 5
// ==========================================
// vectors and reset values
`define TLIC_VEC_HIGH 21'h00_0008
`define TLIC_VEC_LOW 21'h00_0018
`define TLIC_RST_BYTE 8'h00
// ==========================================
// timing: external pin synchronizer depth, in clock cycles
`define TLIC_EXT_SYNC_CYCLES 2
`endif

/* rtl/tlic_pkg.sv */
package tlic_pkg;
	typedef enum logic [2:0] {
		TLIC_IDLE = 3'b001,
		TLIC_LOW = 3'b010,
		TLIC_HIGH = 3'b100
	} tlic_state_t;
	typedef logic [20:0] tlic_addr_t;
endpackage

/* sim/tlic_core_props.sv */
`timescale 1ns/1ps
`include "tlic_params.svh"
// =====
// checker on the core ports
module tlic_core_props (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_cycle_end,
	input wire logic i_return_from_interrupt_instr,
	input wire tlic_pkg::tlic_addr_t i_return_addr,
	input wire logic o_vector_load,
	input wire tlic_pkg::tlic_addr_t o_vector_addr,
	input wire logic o_stack_push,
	input wire tlic_pkg::tlic_addr_t o_push_addr,
	input wire logic o_in_high,
	input wire logic o_in_low
);
	import tlic_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	a_push_with_load:
		assert property (o_vector_load == o_stack_push) else $error("push and load apart");
	a_push_addr_kept:
		assert property (o_stack_push |-> o_push_addr == $past(i_return_addr)) else $error("bad push addr");
	a_vector_legal:
		assert property (o_vector_load |-> o_vector_addr inside {`TLIC_VEC_HIGH, `TLIC_VEC_LOW})
		else $error("bad vector");
	a_low_vec_state:
		assert property (o_vector_load && o_vector_addr == `TLIC_VEC_LOW |-> o_in_low && !o_in_high)
		else $error("low vector state");
	a_take_on_end:
		assert property (o_vector_load |-> $past(i_cycle_end)) else $error("take off cycle end");
	a_one_take:
		assert property (o_vector_load |=> !o_vector_load) else $error("double take");
	a_low_held_off:
		assert property ($past(o_in_high) |-> !(o_vector_load && o_vector_addr == `TLIC_VEC_LOW))
		else $error("low taken in high");
	a_ret_leaves_low:
		assert property (i_return_from_interrupt_instr && o_in_low && !o_in_high |=> !o_in_low)
		else $error("low kept after return");
endmodule
bind tlic_core tlic_core_props u_tlic_core_props (.i_clk, .i_rst_n, .i_cycle_end,
	.i_return_from_interrupt_instr, .i_return_addr, .o_vector_load, .o_vector_addr,
	.o_stack_push, .o_push_addr, .o_in_high, .o_in_low);

/* sim/tlic_core_model.sv */
`timescale 1ns/1ps
// =====
// core sequencer: cycle ends, return pulse, pc
module tlic_core_model (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_slow,
	input wire logic i_ret_req,
	output logic o_cycle_end,
	output logic o_ret,
	output tlic_pkg::tlic_addr_t o_pc
);
	import tlic_pkg::*;
	// slow mode: two-cycle instructions, vectoring only every other cycle
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_cycle_end <= 1'b0;
			o_ret <= 1'b0;
			o_pc <= '0;
		end else begin
			o_cycle_end <= i_slow ? !o_cycle_end : 1'b1;
			o_ret <= i_ret_req;
			o_pc <= o_pc + 21'h00_0001;
		end
	end
endmodule

/* sim/tb.sv */
`timescale 1ns/1ps
`include "tlic_params.svh"
module tb;
	import tlic_pkg::*;
	logic i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, ret_req = 0, slow = 0;
	logic [3:0] i_addr = 0;
	logic [7:0] i_wdata = 0, o_rdata, ev = 0, ext = 0, usb = 0;
	logic cyc_end, ret, o_vector_load, o_stack_push, o_in_high, o_in_low;
	tlic_addr_t pc, o_vector_addr, o_push_addr;
	int n_fail = 0, check_count = 0, n_load = 0, cyc = 0, seen;
	always #12.5 i_clk = ~i_clk;
	tlic_core_model u_tlic_core_model (.i_clk, .i_rst_n, .i_slow(slow), .i_ret_req(ret_req),
		.o_cycle_end(cyc_end), .o_ret(ret), .o_pc(pc));
	tlic_core u_tlic_core (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_event(ev),
		.i_ext_pin(ext), .i_usb_events(usb), .i_cycle_end(cyc_end), .i_return_from_interrupt_instr(ret),
		.i_return_addr(pc), .o_vector_load, .o_vector_addr, .o_stack_push, .o_push_addr, .o_in_high, .o_in_low);
	// =====
	// tasks
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task chk(input string n, input logic [20:0] s, input logic [20:0] e);
		check_count++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value %s exp %h got %h", n, e, s);
		end
	endtask
	// single plain writes only, never a file move
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge i_clk);
		i_rd <= 1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 0;
		#1 chk("rdata", o_rdata, e);
	endtask
	task pulse(input logic [7:0] m);
		@(posedge i_clk);
		ev <= m;
		@(posedge i_clk);
		ev <= 0;
	endtask
	task ret_pulse;
		@(posedge i_clk);
		ret_req <= 1;
		@(posedge i_clk);
		ret_req <= 0;
	endtask
	task wv(input tlic_addr_t a);
		for (int k = 0; k < 20 && !o_vector_load; k++) begin
			@(posedge i_clk);
			#1;
		end
		chk("vector", o_vector_load ? o_vector_addr : 21'h1f_ffff, a);
	endtask
	task quiet(input int n);
		seen = n_load;
		repeat (n) @(posedge i_clk);
		chk("loads", 21'(n_load - seen), 0);
	endtask
	always @(posedge i_clk) if (o_vector_load) n_load <= n_load + 1;
	// cut a hang short
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 4000) begin
			n_fail++;
			report_and_stop();
		end
	end
	// =====
	// sequence
	initial begin
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1;
		rd(`TLIC_OFS_RESET_CONTROL_REG, 8'h00);
		rd(`TLIC_OFS_LEVEL, 8'hff);
		rd(4'hf, 8'h00);
		ext <= 8'h02;
		usb <= 8'h08;
		pulse(8'h01);
		usb <= 0;
		repeat (4) @(posedge i_clk);
		rd(`TLIC_OFS_FLAG, 8'h23);
		quiet(1);
		wr(`TLIC_OFS_FLAG, 8'h00);
		slow <= 1;
		wr(`TLIC_OFS_ENABLE, 8'h08);
		wr(`TLIC_OFS_INTERRUPT_CONTROL_REG, 8'h80);
		pulse(8'h08);
		quiet(8);
		wr(`TLIC_OFS_INTERRUPT_CONTROL_REG, 8'hc0);
		wv(`TLIC_VEC_HIGH);
		rd(`TLIC_OFS_INTERRUPT_CONTROL_REG, 8'h40);
		wr(`TLIC_OFS_FLAG, 8'h00);
		ret_pulse();
		rd(`TLIC_OFS_INTERRUPT_CONTROL_REG, 8'hc0);
		slow <= 0;
		wr(`TLIC_OFS_RESET_CONTROL_REG, 8'h80);
		wr(`TLIC_OFS_LEVEL, 8'h01);
		wr(`TLIC_OFS_ENABLE, 8'h03);
		pulse(8'h03);
		wv(`TLIC_VEC_HIGH);
		rd(`TLIC_OFS_INTERRUPT_CONTROL_REG, 8'h40);
		rd(`TLIC_OFS_STATUS, 8'h04);
		quiet(6);
		wr(`TLIC_OFS_FLAG, 8'h02);
		ret_pulse();
		wv(`TLIC_VEC_LOW);
		chk("in_low", 21'(o_in_low), 21'h00_0001);
		pulse(8'h01);
		wv(`TLIC_VEC_HIGH);
		chk("in_high", 21'(o_in_high), 21'h00_0001);
		rd(`TLIC_OFS_INTERRUPT_CONTROL_REG, 8'h00);
		wr(`TLIC_OFS_FLAG, 8'h00);
		ret_pulse();
		ret_pulse();
		rd(`TLIC_OFS_INTERRUPT_CONTROL_REG, 8'hc0);
		report_and_stop();
	end
endmodule
